//--- src/plc_strap_link_ctrl.sv
// strap capture, link clock gating and link-on clock for the phy
// Summary of operation
// - suspend/resume strap high enables suspend and resume, low disables it
// - link power status high: link clock runs continuously at 49.152 MHz
// - link power status low: link clock clamped low within 25 us
// - link-on indication is a 6.144 MHz clock, not a static level
// - connection strap low selects isolation barrier, high direct connection
// - three power class straps load the power class field of register 4
// - manager capable strap loads the contender bit of register 4
`timescale 1ns/1ps
`default_nettype none
module plc_strap_link_ctrl
    import plc_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic link_power_status_in,
    input wire logic link_wake_request_in,
    input wire logic suspend_resume_select_in,
    input wire logic direct_connect_in,
    input wire logic max_speed_select_in,
    input wire logic [2:0] power_class_straps_in,
    input wire logic manager_capable_strap_in,
    output logic link_clock_out,
    output logic link_wake_indication_out,
    output logic suspend_resume_en_out,
    output logic isolation_mode_out,
    output logic [2:0] max_speed_out,
    output logic [7:0] phy_reg4_out
);
    // ****************************************
    // reset release
    // ****************************************
    logic [1:0] rst_sync_ff;
    logic rst_n;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // ****************************************
    // input synchronisers
    // ****************************************
    localparam int unsigned IN_W = 8;
    logic [IN_W-1:0] raw_in;
    logic [IN_W-1:0] meta_ff;
    logic [IN_W-1:0] sync_ff;

    assign raw_in = {link_power_status_in, suspend_resume_select_in, direct_connect_in,
                     max_speed_select_in, power_class_straps_in, manager_capable_strap_in};

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= raw_in;
            sync_ff <= meta_ff;
        end
    end

    logic pwr_stat_s;
    logic susp_sel_s;
    logic direct_s;
    logic speed_sel_s;
    logic [2:0] pwr_class_s;
    logic mgr_cap_s;
    assign {pwr_stat_s, susp_sel_s, direct_s, speed_sel_s, pwr_class_s, mgr_cap_s} = sync_ff;

    // ****************************************
    // strap capture after reset
    // ****************************************
    logic [1:0] cap_cnt_ff;
    logic [1:0] nxt_cap_cnt;
    logic captured_ff;
    logic nxt_captured;
    logic susp_en_ff;
    logic nxt_susp_en;
    logic isol_ff;
    logic nxt_isol;
    logic [2:0] speed_ff;
    logic [2:0] nxt_speed;
    logic [7:0] reg4_ff;
    logic [7:0] nxt_reg4;
    logic do_cap;

    always_comb begin
        do_cap = !captured_ff && (cap_cnt_ff == CAPTURE_DELAY);
        nxt_cap_cnt = (cap_cnt_ff == CAPTURE_DELAY) ? cap_cnt_ff : cap_cnt_ff + 2'h1;
        nxt_captured = captured_ff | do_cap;
        nxt_susp_en = do_cap ? susp_sel_s : susp_en_ff;
        nxt_isol = do_cap ? !direct_s : isol_ff;
        nxt_speed = do_cap ? (speed_sel_s ? SPEED_S400 : SPEED_S200) : speed_ff;
        nxt_reg4 = reg4_ff;
        nxt_reg4[REG4_LINK_ACTIVE] = pwr_stat_s;
        if (do_cap) begin
            nxt_reg4[REG4_CONTENDER] = mgr_cap_s;
            nxt_reg4[REG4_JITTER_LSB +: 3] = REG4_JITTER_VAL;
            nxt_reg4[REG4_PWR_LSB +: 3] = pwr_class_s;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cap_cnt_ff <= 2'h0;
            captured_ff <= 1'b0;
            susp_en_ff <= 1'b0;
            isol_ff <= 1'b0;
            speed_ff <= SPEED_S200;
            reg4_ff <= 8'h00;
        end else begin
            cap_cnt_ff <= nxt_cap_cnt;
            captured_ff <= nxt_captured;
            susp_en_ff <= nxt_susp_en;
            isol_ff <= nxt_isol;
            speed_ff <= nxt_speed;
            reg4_ff <= nxt_reg4;
        end
    end

    assign suspend_resume_en_out = susp_en_ff;
    assign isolation_mode_out = isol_ff;
    assign max_speed_out = speed_ff;
    assign phy_reg4_out = reg4_ff;

    // ****************************************
    // link clock and link-on clock
    // ****************************************
    plc_nco #(.INC(LINK_CLK_INC)) u_link_clk (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n),
        .run_in(pwr_stat_s),
        .clk_out(link_clock_out)
    );

    plc_nco #(.INC(WAKE_CLK_INC)) u_wake_clk (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n),
        .run_in(link_wake_request_in),
        .clk_out(link_wake_indication_out)
    );

    // ****************************************
    // checks
    // ****************************************
    logic [STOP_CNT_W-1:0] low_cnt_ff;
    logic [STOP_CNT_W-1:0] nxt_low_cnt;

    always_comb begin
        nxt_low_cnt = pwr_stat_s ? '0 : ((low_cnt_ff == STOP_CNT_MAX) ? low_cnt_ff
                                                                  : low_cnt_ff + 1'b1);
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_ff <= '0;
        end else begin
            low_cnt_ff <= nxt_low_cnt;
        end
    end

    lclk_stop_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (low_cnt_ff == STOP_CNT_MAX) |-> !link_clock_out)
        else $error("link clock not clamped after power status low");
    lclk_clamp_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        !pwr_stat_s [*2] |-> !link_clock_out)
        else $error("link clock running while power status low");
    lclk_runs_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (pwr_stat_s && !link_clock_out) |-> ##[1:3] (link_clock_out || !pwr_stat_s))
        else $error("link clock stuck low while powered");
    wake_idle_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        !link_wake_request_in |=> !link_wake_indication_out)
        else $error("link-on output active without request");
    wake_toggle_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (link_wake_request_in && link_wake_indication_out)
            |-> ##[1:10] (!link_wake_indication_out || !link_wake_request_in))
        else $error("link-on output is a static level");
    reg4_pwr_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        do_cap |=> (phy_reg4_out[REG4_PWR_LSB +: 3] == $past(pwr_class_s)))
        else $error("power class field not loaded from straps");
    reg4_cont_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        do_cap |=> (phy_reg4_out[REG4_CONTENDER] == $past(mgr_cap_s)))
        else $error("contender bit not loaded from strap");
    susp_sel_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        do_cap |=> (suspend_resume_en_out == $past(susp_sel_s)))
        else $error("suspend/resume enable not from strap");
    isol_mode_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        do_cap |=> (isolation_mode_out == !$past(direct_s)))
        else $error("isolation mode not from connection strap");
    speed_cap_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        do_cap |=> (max_speed_out == ($past(speed_sel_s) ? SPEED_S400 : SPEED_S200)))
        else $error("speed limit not from speed strap");
    cap_once_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        captured_ff |=> ($stable(suspend_resume_en_out) && $stable(max_speed_out)))
        else $error("strap values changed after capture");
endmodule : plc_strap_link_ctrl
`default_nettype wire

//--- src/plc_pkg.sv
// constants for the strap capture and link clock control block
package plc_pkg;
    // ****************************************
    // clocks
    // ****************************************
    localparam int unsigned SYS_CLK_KHZ = 100000;
    localparam int unsigned LINK_CLK_KHZ = 49152;
    localparam int unsigned WAKE_CLK_KHZ = 6144;
    localparam int unsigned ACC_W = 32;
    localparam logic [ACC_W-1:0] LINK_CLK_INC =
        ACC_W'((64'(LINK_CLK_KHZ) << ACC_W) / 64'(SYS_CLK_KHZ));
    localparam logic [ACC_W-1:0] WAKE_CLK_INC =
        ACC_W'((64'(WAKE_CLK_KHZ) << ACC_W) / 64'(SYS_CLK_KHZ));
    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned SYS_CLK_NS = 10;
    localparam int unsigned LINK_STOP_US = 25;
    localparam int unsigned LINK_STOP_CYC = (LINK_STOP_US * 1000) / SYS_CLK_NS;
    localparam int unsigned STOP_CNT_W = 12;
    localparam logic [STOP_CNT_W-1:0] STOP_CNT_MAX = STOP_CNT_W'(LINK_STOP_CYC);
    localparam logic [1:0] CAPTURE_DELAY = 2'h3;
    // ****************************************
    // register 4 layout and speed codes
    // ****************************************
    localparam int unsigned REG4_LINK_ACTIVE = 7;
    localparam int unsigned REG4_CONTENDER = 6;
    localparam int unsigned REG4_JITTER_LSB = 3;
    localparam int unsigned REG4_PWR_LSB = 0;
    localparam logic [2:0] REG4_JITTER_VAL = 3'h0;
    localparam logic [2:0] SPEED_S200 = 3'h1;
    localparam logic [2:0] SPEED_S400 = 3'h2;
endpackage : plc_pkg

//--- src/plc_nco.sv
// phase accumulator clock generator with run gate and low clamp
`timescale 1ns/1ps
`default_nettype none
module plc_nco
    import plc_pkg::*;
#(
    parameter logic [ACC_W-1:0] INC = LINK_CLK_INC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    output logic clk_out
);
    logic [ACC_W-1:0] acc_ff;
    logic [ACC_W-1:0] nxt_acc;
    logic clk_ff;
    logic nxt_clk;

    always_comb begin
        nxt_acc = run_in ? acc_ff + INC : '0;
        nxt_clk = run_in ? nxt_acc[ACC_W-1] : 1'b0;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc_ff <= '0;
            clk_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            clk_ff <= nxt_clk;
        end
    end

    assign clk_out = clk_ff;
endmodule : plc_nco
`default_nettype wire

//--- tb/plc_link_model.sv
// behavioural link layer controller facing the phy link side
`timescale 1ns/1ps
`default_nettype none
module plc_link_model (
    input wire logic powered_in,
    input wire logic link_clock_in,
    output logic link_power_status_out,
    output var int clock_edges_out
);
    // ****************************************
    // power status and clock watch
    // ****************************************
    assign link_power_status_out = powered_in;
    initial clock_edges_out = 0;
    always @(posedge link_clock_in) begin
        clock_edges_out <= clock_edges_out + 1;
    end
endmodule : plc_link_model
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for strap capture and link clock control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import plc_pkg::*;
    // ****************************************
    // signals and instances
    // ****************************************
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic powered = 1'b0;
    logic wake_req = 1'b0;
    logic [6:0] straps = 7'h00;
    logic link_pwr_stat, lclk, wake, suspend_en, iso;
    logic [2:0] max_speed;
    logic [7:0] reg4;
    int lclk_edges;
    int wake_edges = 0;
    int failures = 0;
    int comparisons = 0;
    int e0;
    always #5 sys_clk = ~sys_clk;
    always @(posedge wake) wake_edges <= wake_edges + 1;
    plc_link_model u_link (.powered_in(powered), .link_clock_in(lclk),
        .link_power_status_out(link_pwr_stat), .clock_edges_out(lclk_edges));
    plc_strap_link_ctrl u_dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
        .link_power_status_in(link_pwr_stat), .link_wake_request_in(wake_req),
        .suspend_resume_select_in(straps[6]), .direct_connect_in(straps[5]),
        .max_speed_select_in(straps[4]), .power_class_straps_in(straps[3:1]),
        .manager_capable_strap_in(straps[0]), .link_clock_out(lclk),
        .link_wake_indication_out(wake), .suspend_resume_en_out(suspend_en),
        .isolation_mode_out(iso), .max_speed_out(max_speed), .phy_reg4_out(reg4));
    // ****************************************
    // compare and report
    // ****************************************
    task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val
    task automatic check_range(input string what, input int lo, input int hi, input int got);
        comparisons++;
        if (got < lo || got > hi) begin
            failures++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : check_range
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    // ****************************************
    // scenarios
    // ****************************************
    task automatic check_straps(input logic [6:0] s);
        check_val("suspend_en", {7'h00, s[6]}, {7'h00, suspend_en});
        check_val("iso", {7'h00, ~s[5]}, {7'h00, iso});
        check_val("speed", {5'h00, s[4] ? SPEED_S400 : SPEED_S200}, {5'h00, max_speed});
        check_val("reg4", {1'b0, s[0], REG4_JITTER_VAL, s[3:1]}, reg4);
    endtask : check_straps
    task automatic test_straps(input logic [6:0] s);
        straps = s;
        rst_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        check_val("rst_outs", 8'h00, {3'h0, lclk, wake, suspend_en, iso, reg4 != 8'h00});
        check_val("rst_speed", {5'h00, SPEED_S200}, {5'h00, max_speed});
        rst_n = 1'b1;
        repeat (12) @(negedge sys_clk);
        check_straps(s);
        straps = ~s;
        repeat (12) @(negedge sys_clk);
        check_straps(s);
        $display("test straps %b done", s);
    endtask : test_straps
    task automatic test_link_clock;
        powered = 1'b1;
        repeat (10) @(negedge sys_clk);
        e0 = lclk_edges;
        repeat (1000) @(negedge sys_clk);
        check_range("lclk_edges", 480, 500, lclk_edges - e0);
        check_val("link_active", 8'h01, {7'h00, reg4[7]});
        powered = 1'b0;
        repeat (2500) @(negedge sys_clk);
        e0 = lclk_edges;
        check_val("lclk_low", 8'h00, {7'h00, lclk});
        repeat (200) @(negedge sys_clk);
        check_range("lclk_stopped", 0, 0, lclk_edges - e0);
        check_val("link_idle", 8'h00, {7'h00, reg4[7] | lclk});
        $display("test link clock done");
    endtask : test_link_clock
    task automatic test_wake;
        wake_req = 1'b1;
        repeat (10) @(negedge sys_clk);
        e0 = wake_edges;
        repeat (1000) @(negedge sys_clk);
        check_range("wake_edges", 58, 65, wake_edges - e0);
        wake_req = 1'b0;
        repeat (2) @(negedge sys_clk);
        e0 = wake_edges;
        repeat (100) @(negedge sys_clk);
        check_range("wake_stopped", 0, 0, wake_edges - e0);
        check_val("wake_low", 8'h00, {7'h00, wake});
        $display("test wake done");
    endtask : test_wake
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        @(negedge sys_clk);
        test_straps(7'b1010110);
        test_straps(7'b0101001);
        test_link_clock();
        test_wake();
        report_and_stop();
    end
    initial begin
        #200000;
        failures++;
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
